/* logic/dsebc_core.sv */
/*
 debug serial error and break control: one-wire open-drain link with
 auto-baud, break/framing/collision detection, return break and breakpoint
 halt/loop control toward the processor.
 assumes the pin input is already synchronous to clk and the debug control
 bits arrive as plain ports held by the command logic outside.
*/
`timescale 1ns/1ps
`default_nettype none
module dsebc_core
  import dsebc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // debug serial pin
  input  wire logic       debugPinIn,
  output logic            debugPinOut,
  output logic            debugPinOe,
  // transmit request
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // received character and command abort
  output dsebc_byte_t     rxByte,
  output logic            cmdAbort,
  // debug control register bits
  input  wire dsebc_ctl_t ctl,
  // processor side
  input  wire logic       opcodeDecode,
  input  wire logic [7:0] opcode,
  output logic            brkReached,
  output logic            cpuStall,
  output logic            loopOnBrk,
  output logic [4:0]      status
);
  dsebc_state_t state;
  logic [BAUD_W-1:0] bitPeriod;
  logic [BAUD_W-1:0] cnt;
  logic [BAUD_W+3:0] lowRun;
  logic [3:0]        bitIdx;
  logic [9:0]        shifter;
  logic [RET_W-1:0]  retCnt;
  logic              halted;
  logic              loopIdle;
  logic              breakSeen;
  logic              frameErr;
  logic              collErr;
  logic              txBit;
  logic              isBreak;
  logic              errEvent;
  logic [BAUD_W-1:0] halfPeriod;
  logic [BAUD_W-1:0] bitLast;

  assign halfPeriod = bitPeriod >> 1;
  // a bit lasts bitPeriod cycles, counted 0 .. bitPeriod-1; no drift over a frame
  assign bitLast    = bitPeriod - 16'h0001;
  // nine bit times of continuous low; held off until baud is known
  assign isBreak = (state != DSEBC_BAUD) && !debugPinIn &&
                   (lowRun >= ({4'h0, bitPeriod} * 20'(BREAK_BITS)));

  // ==========================================================
  // low run counter, counts across every state including transmit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowRun <= '0;
    end else if (debugPinIn) begin
      lowRun <= '0;
    end else if (lowRun != '1) begin
      lowRun <= lowRun + 20'h00001;
    end
  end

  // ==========================================================
  // link state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= DSEBC_BAUD;
      bitPeriod <= '0;
      cnt       <= '0;
      bitIdx    <= '0;
      shifter   <= '0;
      retCnt    <= '0;
      txBit     <= 1'b1;
      frameErr  <= 1'b0;
      collErr   <= 1'b0;
      breakSeen <= 1'b0;
    end else begin
      frameErr  <= 1'b0;
      collErr   <= 1'b0;
      breakSeen <= 1'b0;
      if (isBreak && state != DSEBC_RETBK && state != DSEBC_HOLD) begin
        breakSeen <= 1'b1;
        state     <= DSEBC_RETBK;
        retCnt    <= '0;
        txBit     <= 1'b1;
      end else begin
        unique case (state)
          DSEBC_BAUD: begin
            // the first low interval of the first character is one bit time
            if (!debugPinIn) begin
              if (cnt != BAUD_MAX) cnt <= cnt + 16'h0001;
            end else if (cnt != '0) begin
              bitPeriod <= cnt;
              cnt       <= '0;
              state     <= DSEBC_IDLE;
            end
          end
          DSEBC_IDLE: begin
            cnt <= '0;
            if (!debugPinIn) begin
              state  <= DSEBC_RX;
              bitIdx <= '0;
            end else if (txValid) begin
              shifter <= {1'b1, txData, 1'b0};
              bitIdx  <= '0;
              state   <= DSEBC_TX;
            end
          end
          DSEBC_RX: begin
            // first wait is half a bit to land mid-cell
            if ((bitIdx == 4'd0 && cnt == halfPeriod) ||
                (bitIdx != 4'd0 && cnt == bitLast)) begin
              cnt     <= '0;
              bitIdx  <= bitIdx + 4'd1;
              shifter <= {debugPinIn, shifter[9:1]};
              if (bitIdx == 4'd9) begin
                state <= DSEBC_IDLE;
                if (!debugPinIn) begin
                  frameErr <= 1'b1;
                  state    <= DSEBC_RETBK;
                  retCnt   <= '0;
                end
              end
            end else begin
              cnt <= cnt + 16'h0001;
            end
          end
          DSEBC_TX: begin
            txBit <= shifter[0];
            if (cnt == halfPeriod && txBit && !debugPinIn) begin
              collErr <= 1'b1;
              state   <= DSEBC_RETBK;
              retCnt  <= '0;
              txBit   <= 1'b1;
            end else if (cnt == bitLast) begin
              cnt     <= '0;
              shifter <= {1'b1, shifter[9:1]};
              bitIdx  <= bitIdx + 4'd1;
              if (bitIdx == 4'd9) begin
                state <= DSEBC_IDLE;
                txBit <= 1'b1;
              end
            end else begin
              cnt <= cnt + 16'h0001;
            end
          end
          DSEBC_RETBK: begin
            txBit <= 1'b0;
            if (retCnt == RET_LAST) begin
              state <= DSEBC_HOLD;
              txBit <= 1'b1;
            end else begin
              retCnt <= retCnt + 13'h0001;
            end
          end
          DSEBC_HOLD: begin
            // auto-baud restarts only once the line is released high
            bitPeriod <= '0;
            cnt       <= '0;
            if (debugPinIn) state <= DSEBC_BAUD;
          end
          default: state <= DSEBC_BAUD;
        endcase
      end
    end
  end

  assign errEvent    = breakSeen | frameErr | collErr;
  assign cmdAbort    = errEvent;
  // only ever pull low; a high bit is a released line
  assign debugPinOut = 1'b0;
  assign debugPinOe  = (state == DSEBC_RETBK) || (state == DSEBC_TX && !txBit);
  assign txReady     = (state == DSEBC_IDLE) && debugPinIn;

  // ==========================================================
  // received character
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxByte <= '0;
    end else begin
      rxByte.valid <= 1'b0;
      if (state == DSEBC_RX && bitIdx == 4'd9 && cnt == bitLast && debugPinIn) begin
        rxByte.valid <= 1'b1;
        rxByte.data  <= shifter[9:2];
      end
    end
  end

  // ==========================================================
  // breakpoint control; control bits untouched by link errors
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      brkReached <= 1'b0;
      halted     <= 1'b0;
      loopIdle   <= 1'b0;
    end else begin
      brkReached <= opcodeDecode && (opcode == BRK_OPCODE);
      if (brkReached && ctl.brkEnable && !ctl.brkLoop) begin
        halted <= 1'b1;
      end else if (loopIdle && !ctl.brkLoop && ctl.brkEnable) begin
        halted <= 1'b1;
      end else if (ctl.dbgModeReq) begin
        halted <= 1'b1;
      end else if (!ctl.dbgModeReq && !ctl.brkEnable) begin
        halted <= 1'b0;
      end
      if (brkReached && ctl.brkEnable && ctl.brkLoop) begin
        loopIdle <= 1'b1;
      end else if (!ctl.brkLoop || !ctl.brkEnable || halted) begin
        loopIdle <= 1'b0;
      end
    end
  end

  // looping leaves the stall low so dma and interrupts still run
  assign cpuStall  = halted;
  assign loopOnBrk = loopIdle;
  assign status    = {collErr, frameErr, breakSeen, halted, loopIdle};

  // ==========================================================
  // checks
  sequence s_err;
    errEvent;
  endsequence
  sequence s_retbreak;
    debugPinOe [*8];
  endsequence
  a_err_return_break: assert property (@(posedge clk) disable iff (!rst_b)
    s_err |=> s_retbreak) else $error("no return break after error");
  a_open_drain_only: assert property (@(posedge clk) disable iff (!rst_b)
    debugPinOut == 1'b0) else $error("pin driven high");
  a_break_detect: assert property (@(posedge clk) disable iff (!rst_b)
    (isBreak && state == DSEBC_TX) |=> (state == DSEBC_RETBK)) else $error("break missed in tx");
  a_frame_error: assert property (@(posedge clk) disable iff (!rst_b)
    frameErr |-> (state == DSEBC_RETBK)) else $error("frame error without return break");
  a_hold_low: assert property (@(posedge clk) disable iff (!rst_b)
    (state == DSEBC_HOLD && !debugPinIn) |=> (state == DSEBC_HOLD)) else $error("left reset early");
  a_brk_halt: assert property (@(posedge clk) disable iff (!rst_b)
    (brkReached && ctl.brkEnable && !ctl.brkLoop) |=> cpuStall) else $error("no halt on breakpoint");
  a_brk_ignore: assert property (@(posedge clk) disable iff (!rst_b)
    (brkReached && !ctl.brkEnable && !cpuStall && !ctl.dbgModeReq) |=> !cpuStall)
    else $error("disabled breakpoint stalled");
  a_loop_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (brkReached && ctl.brkEnable && ctl.brkLoop) |=> (status[ST_IDLE] && !cpuStall))
    else $error("loop idle not shown");
  a_halt_kept: assert property (@(posedge clk) disable iff (!rst_b)
    (cpuStall && breakSeen && ctl.brkEnable) |=> cpuStall) else $error("break released halt");
endmodule
`default_nettype wire

/* logic/dsebc_pkg.sv */
/*
 package for the debug serial error and break control block: timing counts,
 field positions and the packed carriers shared by the design.
 assumes a 40 MHz system clock.
*/
package dsebc_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned BREAK_BITS      = 9;
  localparam int unsigned RETURN_BREAK_CY = 4096;
  localparam int unsigned BAUD_W          = 16;
  localparam int unsigned RET_W           = 13;
  localparam logic [12:0] RET_LAST        = 13'(RETURN_BREAK_CY - 1);
  localparam logic [7:0]  BRK_OPCODE      = 8'h00;
  localparam logic [15:0] BAUD_MAX        = 16'hffff;

  // ==========================================================
  // status field positions
  localparam int unsigned ST_IDLE   = 0;
  localparam int unsigned ST_HALTED = 1;
  localparam int unsigned ST_BREAK  = 2;
  localparam int unsigned ST_FRAME  = 3;
  localparam int unsigned ST_COLL   = 4;

  // ==========================================================
  // link states
  typedef enum logic [2:0] {
    DSEBC_BAUD  = 3'b000,
    DSEBC_IDLE  = 3'b001,
    DSEBC_RX    = 3'b010,
    DSEBC_TX    = 3'b011,
    DSEBC_RETBK = 3'b100,
    DSEBC_HOLD  = 3'b101
  } dsebc_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } dsebc_byte_t;

  typedef struct packed {
    logic brkEnable;
    logic brkLoop;
    logic dbgModeReq;
  } dsebc_ctl_t;
endpackage

/* sim/dsebc_host.sv */
/*
 host debugger model on the open-drain debug pin.
 assumes the bench pulls hostOe itself for sync pulses and breaks.
*/
`timescale 1ns/1ps
`default_nettype none
module dsebc_host (
  // clock
  input  wire logic clk,
  // pin
  input  wire logic dutOe,
  output logic      pin
);
  logic hostOe = 1'b0;
  // pulled up; either party only pulls low
  assign pin = ~(hostOe | dutOe);
  // badStop pulls the stop bit low to provoke a framing error
  task automatic sendChar(input logic [7:0] d, input int bp, input logic badStop);
    @(posedge clk);
    hostOe <= 1'b1;
    repeat (bp) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      hostOe <= ~d[i];
      repeat (bp) @(posedge clk);
    end
    hostOe <= badStop;
    repeat (bp) @(posedge clk);
    hostOe <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
/*
 bench for the debug serial error and break block.
 assumes the host model on the pin; bit period BP set by the sync pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dsebc_pkg::*;
  localparam int BP = 16;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pin;
  logic        oe;
  logic        pinOut;
  logic        txValid = 1'b0;
  logic [7:0]  txData = 8'h00;
  logic        txReady;
  dsebc_byte_t rx;
  logic        abort;
  dsebc_ctl_t  ctl = '0;
  logic        opDec = 1'b0;
  logic [7:0]  op = 8'h00;
  logic        breakpoint_opcode;
  logic        stall;
  logic        loopB;
  logic [4:0]  status;
  logic [3:0]  seen = 4'h0;
  logic        clr = 1'b0;
  logic [7:0]  rxLast = 8'h00;
  logic [7:0]  d;
  logic [9:0]  got;
  logic [2:0]  w;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          seed = 32'ha53f7625;

  always #12.5 clk = ~clk;

  dsebc_core dut (.clk(clk), .rst_b(rst_b), .debugPinIn(pin), .debugPinOut(pinOut),
    .debugPinOe(oe), .txValid(txValid), .txData(txData), .txReady(txReady),
    .rxByte(rx), .cmdAbort(abort), .ctl(ctl), .opcodeDecode(opDec), .opcode(op),
    .brkReached(breakpoint_opcode), .cpuStall(stall), .loopOnBrk(loopB), .status(status));
  dsebc_host host (.clk(clk), .dutOe(oe), .pin(pin));

  // ==========================================================
  // sticky flags; pulses last one cycle only
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seen <= clr ? 4'h0 : seen | {status[ST_COLL], status[ST_FRAME], status[ST_BREAK], abort};
    if (rx.valid === 1'b1)
      rxLast <= rx.data;
    if (cyc == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [1:0] expHalt(input int k, input int j);
    if (j == 0 || k % 2 == 0)
      return 2'b00;
    return (k > 1) ? 2'b01 : 2'b10;
  endfunction

  task automatic clear();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  task automatic sync();
    host.hostOe <= 1'b1;
    repeat (BP) @(posedge clk);
    host.hostOe <= 1'b0;
    repeat (3 * BP) @(negedge clk);
    chk(txReady === 1'b1, "not ready after sync");
    @(posedge clk);
  endtask

  // waits for the abort, then times the pin pull that follows it
  task automatic expectRet();
    int n = 0;
    while (abort !== 1'b1) @(negedge clk);
    while (oe !== 1'b1) @(negedge clk);
    while (oe === 1'b1) begin
      @(negedge clk);
      n++;
    end
    chk(n == RETURN_BREAK_CY, "return break length");
    chk(pinOut === 1'b0, "pin driven high");
    @(posedge clk);
  endtask

  task automatic send(input logic [7:0] v, input logic look);
    txData <= v;
    txValid <= 1'b1;
    do @(negedge clk); while (txReady !== 1'b1);
    @(posedge clk);
    txValid <= 1'b0;
    if (look) begin
      while (pin !== 1'b0) @(negedge clk);
      repeat (BP / 2) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
        got[i] = pin;
        repeat (BP) @(negedge clk);
      end
      @(posedge clk);
    end
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(txReady === 1'b0, "ready before baud");
    @(posedge clk);
    sync();
    repeat (4) begin
      d = 8'($random(seed));
      host.sendChar(d, BP, 1'b0);
      repeat (2) @(posedge clk);
      chk(rxLast === d, "rx data");
    end
    repeat (2) begin
      d = 8'($random(seed));
      send(d, 1'b1);
      chk(got === {1'b1, d, 1'b0}, "tx frame");
    end
    clear();
    fork
      expectRet();
      // bit 0 high keeps the low run short of a break, so framing is what trips
      host.sendChar(8'($random(seed)) | 8'h01, BP, 1'b1);
    join
    chk(seen[2] === 1'b1, "no framing flag");
    sync();
    clear();
    send(8'hff, 1'b0);
    fork
      expectRet();
      begin
        repeat (2 * BP) @(posedge clk);
        // host pulls the line while we transmit
        host.hostOe <= 1'b1;
        repeat (BP) @(posedge clk);
        host.hostOe <= 1'b0;
      end
    join
    chk(seen[3] === 1'b1, "no collision flag");
    sync();
    for (int k = 0; k < 4; k++) begin
      ctl <= '{brkEnable: k[0], brkLoop: k[1], dbgModeReq: 1'b0};
      for (int j = 0; j < 2; j++) begin
        op <= j ? BRK_OPCODE : 8'($random(seed)) | 8'h01;
        opDec <= 1'b1;
        @(posedge clk);
        opDec <= 1'b0;
        w = 3'h0;
        repeat (3) begin
          @(negedge clk);
          w = {w[1:0], breakpoint_opcode};
        end
        chk(j ? $onehot(w) : w === 3'h0, "breakpoint signal");
        chk({stall, loopB} === expHalt(k, j), "halt or loop");
        chk({status[ST_HALTED], status[ST_IDLE]} === expHalt(k, j), "status");
        @(posedge clk);
      end
      if (k == 3) begin
        ctl.brkLoop <= 1'b0;
        repeat (2) @(negedge clk);
        chk({stall, loopB} === 2'b10, "loop not halted");
        @(posedge clk);
        clear();
        host.hostOe <= 1'b1;
        expectRet();
        chk(seen[1] === 1'b1, "no break flag");
        chk(txReady === 1'b0 && stall === 1'b1, "left reset or halt");
        host.hostOe <= 1'b0;
        // the line must be seen high before the sync pulse, or the unit stays held
        repeat (2) @(posedge clk);
        sync();
      end
      ctl <= '0;
      repeat (3) @(negedge clk);
      chk({stall, loopB} === 2'b00, "halt not released");
      @(posedge clk);
    end
    stop_test();
  end
endmodule
`default_nettype wire
